// ---- fwp_map.svh ----
// Register offsets, fields, resets and timing counts of the row programmer
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FWP_OFS_CTRL 8'h00
`define FWP_OFS_DATA_POINTER 8'h04
`define FWP_OFS_STAT 8'h0c
`define FWP_OFS_NMI_STATUS_REG 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FWP_CTRL_START 0
`define FWP_CTRL_BG 1
`define FWP_CTRL_NMIEN 2
`define FWP_STAT_CARRY 0
`define FWP_STAT_BUSY 1
`define FWP_STAT_PROG 2
`define FWP_STAT_RDY 3
`define FWP_STAT_HOLD 4
`define FWP_NMI_STATUS_REG_DONE 0
// ----------------------------------------
// Values and timing
// ----------------------------------------
`define FWP_DATA_POINTER_RESET 16'h0000
`define FWP_ROW_BYTES 32
`define FWP_ROW_STEP 16'h0020
`define FWP_R0_ADDR 8'h18
`define FWP_RESP_OKAY 2'b00
`define FWP_RESP_SLVERR 2'b10
`define FWP_CLK_PERIOD_NS 50
`define FWP_PROG_TIME_NS 2600000
`define FWP_PROG_CYCLES (`FWP_PROG_TIME_NS / `FWP_CLK_PERIOD_NS)
`define FWP_INIT_CYCLES 4
`endif

// ---- fwp_pkg.sv ----
// Types shared by the row programmer
package fwp_pkg;
  typedef logic [7:0] fwp_byte_t;
  // Gray codes along the normal path
  typedef enum logic [2:0] {
    FWP_IDLE = 3'b000,
    FWP_CHECK = 3'b001,
    FWP_INIT = 3'b011,
    FWP_PTR = 3'b010,
    FWP_LOAD = 3'b110,
    FWP_PROG = 3'b111,
    FWP_WAIT = 3'b101,
    FWP_DONE = 3'b100
  } fwp_state_t;
endpackage : fwp_pkg

// ---- fwp_row_program.sv ----
// Flash row program sequencer with an AXI4-Lite register slave
// Notes on behaviour
// - Same row may take a second pass
// - Each accepted request that is not aborted programs exactly 32 row bytes
// - Checks and init run before programming
// - Row from pointer, source via RAM 18h
// - Background returns control, bank stays locked
// - Background carry: 0 started, 1 not
// - Background done sets flag, NMI if enabled
// - After done bank returns to read
// - Pointer advances 20h only when accepted
// - Blocking mode holds CPU until finished
// - Never program and read mode together
// - Blocking carry 1 on protection or NMI
// - Blocking mode clears done flag
// - Programming only sets bits
`timescale 1ns/1ps
`include "fwp_map.svh"

module fwp_row_program #(
  parameter int ROW_BYTES = `FWP_ROW_BYTES,
  parameter int PROG_CYCLES = `FWP_PROG_CYCLES,
  parameter int INIT_CYCLES = `FWP_INIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Internal RAM read port, read without latency
  output logic [7:0] iramAddr,
  input wire fwp_pkg::fwp_byte_t iramRdData,
  // Flash bank
  output logic [15:0] flashAddr,
  output logic [7:0] flashData,
  output logic flashWe,
  output logic flashProgMode,
  output logic flashReadReady,
  // CPU side
  input wire logic protMode1,
  input wire logic nmiEvent,
  output logic cpuHold,
  output logic flashNmi
);
  import fwp_pkg::*;

  localparam int IW = $clog2(ROW_BYTES) + 1;
  localparam int CW = $clog2(PROG_CYCLES + 1);

  if (ROW_BYTES != 32 || PROG_CYCLES < 1 || INIT_CYCLES < 1 || INIT_CYCLES > PROG_CYCLES) begin : g_bad
    $error("fwp_row_program: unsupported parameters");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  fwp_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [IW-1:0] idx_q, idx_d;
  logic bg_q, bg_d, bgCfg_q, bgCfg_d, nmiEn_q, nmiEn_d;
  logic carry_q, carry_d, fail_q, fail_d, doneFlag_q, doneFlag_d;
  logic [15:0] data_pointer_q, data_pointer_d, rowBase_q, rowBase_d;
  logic flashNmi_q, flashNmi_d, cpuHold_q, cpuHold_d;
  logic progMode_q, progMode_d, ready_q, ready_d;
  logic [7:0] iramAddr_q, iramAddr_d, fData_q, fData_d;
  logic [15:0] fAddr_q, fAddr_d;
  logic fWe_q, fWe_d;
  fwp_byte_t rowBuf_q [ROW_BYTES];
  // Bus state
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wrEn, startReq, rowOk, busy;

  assign wrEn = awHave_q && wHave_q && !bvalid_q;
  assign startReq = wrEn && awAddr_q == `FWP_OFS_CTRL && wStrb_q[0] && wData_q[`FWP_CTRL_START];
  assign busy = state_q != FWP_IDLE;
  assign rowOk = !protMode1 && data_pointer_q[4:0] == 5'h00;

  // ----------------------------------------
  // Bus slave: write and read channels
  // ----------------------------------------
  always_comb begin
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid && awready_q) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (wrEn) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `FWP_RESP_OKAY;
      if (!(awAddr_q inside {`FWP_OFS_CTRL, `FWP_OFS_DATA_POINTER, `FWP_OFS_STAT, `FWP_OFS_NMI_STATUS_REG})) begin
        bresp_d = `FWP_RESP_SLVERR;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `FWP_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr)
        `FWP_OFS_CTRL: begin
          rdata_d[`FWP_CTRL_BG] = bgCfg_q;
          rdata_d[`FWP_CTRL_NMIEN] = nmiEn_q;
        end
        `FWP_OFS_DATA_POINTER: rdata_d[15:0] = data_pointer_q;
        `FWP_OFS_STAT: begin
          rdata_d[`FWP_STAT_CARRY] = carry_q;
          rdata_d[`FWP_STAT_BUSY] = busy;
          rdata_d[`FWP_STAT_PROG] = progMode_q;
          rdata_d[`FWP_STAT_RDY] = ready_q;
          rdata_d[`FWP_STAT_HOLD] = cpuHold_q;
        end
        `FWP_OFS_NMI_STATUS_REG: rdata_d[`FWP_NMI_STATUS_REG_DONE] = doneFlag_q;
        default: rresp_d = `FWP_RESP_SLVERR;
      endcase
    end
    // One transfer in flight per direction keeps the slave simple
    awready_d = !awHave_d && !bvalid_d;
    wready_d = !wHave_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else begin
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    bg_d = bg_q;
    bgCfg_d = bgCfg_q;
    nmiEn_d = nmiEn_q;
    carry_d = carry_q;
    fail_d = fail_q;
    doneFlag_d = doneFlag_q;
    data_pointer_d = data_pointer_q;
    rowBase_d = rowBase_q;
    flashNmi_d = 1'b0;
    cpuHold_d = cpuHold_q;
    progMode_d = progMode_q;
    ready_d = ready_q;
    iramAddr_d = iramAddr_q;
    fAddr_d = fAddr_q;
    fData_d = fData_q;
    fWe_d = 1'b0;
    // Software writes; pointer writes are ignored while a request runs
    if (wrEn && wStrb_q[0]) begin
      if (awAddr_q == `FWP_OFS_CTRL) begin
        bgCfg_d = wData_q[`FWP_CTRL_BG];
        nmiEn_d = wData_q[`FWP_CTRL_NMIEN];
      end
      if (awAddr_q == `FWP_OFS_NMI_STATUS_REG) begin
        doneFlag_d = wData_q[`FWP_NMI_STATUS_REG_DONE];
      end
      if (awAddr_q == `FWP_OFS_DATA_POINTER && !busy) begin
        data_pointer_d[7:0] = wData_q[7:0];
      end
    end
    if (wrEn && wStrb_q[1] && awAddr_q == `FWP_OFS_DATA_POINTER && !busy) begin
      data_pointer_d[15:8] = wData_q[15:8];
    end
    if (startReq && busy) begin
      carry_d = 1'b1;
    end
    case (state_q)
      FWP_IDLE: begin
        if (startReq) begin
          bg_d = wData_q[`FWP_CTRL_BG];
          state_d = FWP_CHECK;
        end
      end
      FWP_CHECK: begin
        // Validity check before any bank state changes
        if (rowOk) begin
          rowBase_d = data_pointer_q;
          progMode_d = 1'b1;
          ready_d = 1'b0;
          cpuHold_d = !bg_q;
          iramAddr_d = `FWP_R0_ADDR;
          fail_d = 1'b0;
          cnt_d = '0;
          carry_d = 1'b0;
          if (bg_q) begin
            data_pointer_d = data_pointer_q + `FWP_ROW_STEP;
          end
          state_d = FWP_INIT;
        end else begin
          carry_d = 1'b1;
          state_d = FWP_IDLE;
        end
      end
      FWP_INIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(INIT_CYCLES - 1)) begin
          state_d = FWP_PTR;
        end
      end
      FWP_PTR: begin
        iramAddr_d = iramRdData;
        idx_d = '0;
        state_d = FWP_LOAD;
      end
      FWP_LOAD: begin
        iramAddr_d = iramAddr_q + 8'h01;
        idx_d = idx_q + 1'b1;
        if (idx_q == IW'(ROW_BYTES - 1)) begin
          idx_d = '0;
          state_d = FWP_PROG;
        end
      end
      FWP_PROG: begin
        // Cells only take ones; a zero byte leaves the cell as it was
        fWe_d = 1'b1;
        fAddr_d = rowBase_q + 16'(idx_q);
        fData_d = rowBuf_q[idx_q[IW-2:0]];
        idx_d = idx_q + 1'b1;
        if (idx_q == IW'(ROW_BYTES - 1)) begin
          cnt_d = '0;
          state_d = FWP_WAIT;
        end
      end
      FWP_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(PROG_CYCLES - 1)) begin
          state_d = FWP_DONE;
        end
      end
      FWP_DONE: begin
        progMode_d = 1'b0;
        ready_d = 1'b1;
        cpuHold_d = 1'b0;
        state_d = FWP_IDLE;
      end
      default: state_d = FWP_IDLE;
    endcase
    // A critical NMI aborts a blocking request
    if (!bg_q && nmiEvent && state_q inside {FWP_INIT, FWP_PTR, FWP_LOAD, FWP_PROG, FWP_WAIT}) begin
      fail_d = 1'b1;
      fWe_d = 1'b0;
      state_d = FWP_DONE;
    end
    // Hardware set or clear overrides a software write in the same cycle
    if (state_q == FWP_DONE) begin
      if (bg_q) begin
        doneFlag_d = 1'b1;
        flashNmi_d = nmiEn_q;
      end else begin
        doneFlag_d = 1'b0;
        carry_d = fail_q;
        if (!fail_q) begin
          data_pointer_d = data_pointer_q + `FWP_ROW_STEP;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FWP_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      bg_q <= 1'b0;
      bgCfg_q <= 1'b0;
      nmiEn_q <= 1'b0;
      carry_q <= 1'b0;
      fail_q <= 1'b0;
      doneFlag_q <= 1'b0;
      data_pointer_q <= `FWP_DATA_POINTER_RESET;
      rowBase_q <= 16'h0000;
      flashNmi_q <= 1'b0;
      cpuHold_q <= 1'b0;
      progMode_q <= 1'b0;
      ready_q <= 1'b1;
      iramAddr_q <= 8'h00;
      fAddr_q <= 16'h0000;
      fData_q <= 8'h00;
      fWe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      bg_q <= bg_d;
      bgCfg_q <= bgCfg_d;
      nmiEn_q <= nmiEn_d;
      carry_q <= carry_d;
      fail_q <= fail_d;
      doneFlag_q <= doneFlag_d;
      data_pointer_q <= data_pointer_d;
      rowBase_q <= rowBase_d;
      flashNmi_q <= flashNmi_d;
      cpuHold_q <= cpuHold_d;
      progMode_q <= progMode_d;
      ready_q <= ready_d;
      iramAddr_q <= iramAddr_d;
      fAddr_q <= fAddr_d;
      fData_q <= fData_d;
      fWe_q <= fWe_d;
    end
  end

  // Row buffer, one byte per entry, filled in load order
  for (genvar g = 0; g < ROW_BYTES; g++) begin : g_buf
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        rowBuf_q[g] <= 8'h00;
      end else if (state_q == FWP_LOAD && idx_q == IW'(g)) begin
        rowBuf_q[g] <= iramRdData;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign iramAddr = iramAddr_q;
  assign flashAddr = fAddr_q;
  assign flashData = fData_q;
  assign flashWe = fWe_q;
  assign flashProgMode = progMode_q;
  assign flashReadReady = ready_q;
  assign cpuHold = cpuHold_q;
  assign flashNmi = flashNmi_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [IW-1:0] weCnt_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      weCnt_q <= '0;
    end else if (state_q == FWP_CHECK) begin
      weCnt_q <= '0;
    end else if (fWe_q) begin
      weCnt_q <= weCnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_ROW_COUNT: assert property ((state_q == FWP_WAIT && $past(state_q) == FWP_WAIT) |-> weCnt_q == IW'(ROW_BYTES))
    else $error("row write count wrong");
  AST_ROW_ADDR: assert property (fWe_q |-> fAddr_q[15:5] == rowBase_q[15:5])
    else $error("write left the row");
  AST_EXCL: assert property (!(progMode_q && ready_q))
    else $error("program and read mode together");
  AST_CHECK_FIRST: assert property ($rose(progMode_q) |-> $past(state_q) == FWP_CHECK && $past(rowOk))
    else $error("program mode without check");
  AST_R0: assert property (state_q == FWP_PTR |-> iramAddr_q == `FWP_R0_ADDR)
    else $error("source pointer not fetched from 18h");
  AST_BG_ACCEPT: assert property ((state_q == FWP_CHECK && bg_q && rowOk) |=> !carry_q && data_pointer_q == $past(data_pointer_q) + `FWP_ROW_STEP)
    else $error("accept did not clear carry and step pointer");
  AST_REJECT: assert property ((state_q == FWP_CHECK && !rowOk) |=> carry_q && $stable(data_pointer_q) && state_q == FWP_IDLE)
    else $error("reject not reported");
  AST_BUSY_REJ: assert property ((startReq && state_q inside {FWP_INIT, FWP_PTR, FWP_LOAD, FWP_PROG, FWP_WAIT}) |=> carry_q)
    else $error("busy request not refused");
  AST_BG_FREE: assert property ((bg_q && state_q == FWP_PROG) |-> !cpuHold_q && progMode_q)
    else $error("background mode holds cpu");
  AST_HOLD: assert property ((!bg_q && state_q inside {FWP_LOAD, FWP_PROG, FWP_WAIT}) |-> cpuHold_q)
    else $error("blocking mode released cpu");
  AST_DONE_NMI: assert property ((state_q == FWP_DONE && bg_q) |=> doneFlag_q && flashNmi_q == $past(nmiEn_q))
    else $error("done flag or nmi missing");
  AST_BLK_CLR: assert property ((state_q == FWP_DONE && !bg_q) |=> !doneFlag_q && !cpuHold_q && ready_q)
    else $error("blocking end not clean");
  AST_ABORT: assert property ((!bg_q && nmiEvent && state_q inside {FWP_INIT, FWP_PTR, FWP_LOAD, FWP_PROG, FWP_WAIT})
    |=> state_q == FWP_DONE ##1 carry_q)
    else $error("nmi did not fail blocking request");
  AST_READY: assert property ((state_q == FWP_WAIT && cnt_q == CW'(PROG_CYCLES - 1)) |-> ##2 ready_q)
    else $error("bank not back to read");

  COV_BG: cover property (state_q == FWP_DONE && bg_q && nmiEn_q);
  COV_BLK: cover property (state_q == FWP_DONE && !bg_q && !fail_q);
  COV_ABORT: cover property (state_q == FWP_DONE && fail_q);
  COV_BUSY: cover property (startReq && busy);
endmodule : fwp_row_program

// ---- fwp_mem_model.sv ----
// Internal RAM and flash array model facing the row programmer
`timescale 1ns/1ps

module fwp_mem_model (
  // Clock
  input wire logic clock,
  // RAM read port
  input wire logic [7:0] iramAddr,
  output fwp_pkg::fwp_byte_t iramRdData,
  // Flash write port
  input wire logic [15:0] flashAddr,
  input wire logic [7:0] flashData,
  input wire logic flashWe
);
  import fwp_pkg::*;
  fwp_byte_t ram [256];
  fwp_byte_t flash [4096];
  // ----------------------------------------
  // RAM read
  // ----------------------------------------
  // Zero-latency read, as the programmer expects
  assign iramRdData = ram[iramAddr];
  // ----------------------------------------
  // Flash cells
  // ----------------------------------------
  // Cells start erased at zero
  initial begin
    for (int i = 0; i < 4096; i++) begin
      flash[i] = 8'h00;
    end
  end
  // A pulse only sets bits, so a second pass of zeros keeps older bytes
  always @(posedge clock) begin
    if (flashWe === 1'b1) begin
      flash[flashAddr[11:0]] <= flash[flashAddr[11:0]] | flashData;
    end
  end
endmodule : fwp_mem_model

// ---- fwp_row_program_bench.sv ----
// Self-checking bench for the flash row program sequencer
`timescale 1ns/1ps
`include "fwp_map.svh"
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin errCount++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module fwp_row_program_bench;
  import fwp_pkg::*;
  // Short program wait keeps the run brief
  localparam int TB_PROG = 20;
  int errCount = 0;
  int cmpCount = 0;
  int nmiCount = 0;
  int cycles = 0;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic protMode1 = 1'b0;
  logic nmiEvent = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] iramAddr, flashData;
  fwp_byte_t iramRdData;
  logic [15:0] flashAddr;
  logic flashWe, flashProgMode, flashReadReady, cpuHold, flashNmi;

  fwp_row_program #(.PROG_CYCLES(TB_PROG)) u_dut (
    .clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .iramAddr(iramAddr),
    .iramRdData(iramRdData), .flashAddr(flashAddr), .flashData(flashData), .flashWe(flashWe),
    .flashProgMode(flashProgMode), .flashReadReady(flashReadReady), .protMode1(protMode1),
    .nmiEvent(nmiEvent), .cpuHold(cpuHold), .flashNmi(flashNmi));

  fwp_mem_model u_mem (.clock(clock), .iramAddr(iramAddr), .iramRdData(iramRdData),
    .flashAddr(flashAddr), .flashData(flashData), .flashWe(flashWe));

  // ----------------------------------------
  // Clock, pulse counter and hang guard
  // ----------------------------------------
  initial begin
    forever #25 clock = ~clock;
  end
  // Guard sized well above five program runs plus polling
  always @(posedge clock) begin
    cycles++;
    if (flashNmi === 1'b1) nmiCount++;
    if (cycles == 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end

  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tallyAndFinish

  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (!awDone && s_axi_awready === 1'b1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] expByte(input int mode, input int i);
    case (mode)
      0: return (i < 16) ? 8'(i * 3 + 1) : 8'h00;
      1: return (i < 16) ? 8'h00 : 8'(i + 8'h80);
      2: return 8'(i) ^ 8'h5a;
      default: return 8'h00;
    endcase
  endfunction : expByte

  // Source pointer goes to RAM 18h, data follows at src
  task automatic fill(input logic [7:0] src, input int mode);
    u_mem.ram[8'h18] = src;
    for (int i = 0; i < 32; i++) u_mem.ram[src + i] = expByte(mode, i);
  endtask : fill

  // Reads back the array, as code-space reads would
  task automatic chk_row(input logic [15:0] row, input int m0, input int m1);
    for (int i = 0; i < 32; i++) begin
      `CHK("flash byte", expByte(m0, i) | expByte(m1, i), u_mem.flash[row[11:0] + i])
    end
  endtask : chk_row

  task automatic start(input logic [15:0] row, input logic [2:0] ctrl);
    logic [1:0] r;
    axi_wr(`FWP_OFS_DATA_POINTER, {16'h0, row}, r);
    axi_wr(`FWP_OFS_CTRL, {29'h0, ctrl}, r);
  endtask : start

  task automatic wait_idle(output logic [31:0] d);
    logic [1:0] r;
    do axi_rd(`FWP_OFS_STAT, d, r); while (d[`FWP_STAT_BUSY] !== 1'b0);
  endtask : wait_idle

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("register word", ex, d)
  endtask : rd_chk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(`FWP_OFS_STAT, 32'h00000008);
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h0);
    axi_rd(8'h20, d, r);
    `CHK("unmapped read resp", `FWP_RESP_SLVERR, r)
    axi_wr(8'h20, 32'h1, r);
    `CHK("unmapped write resp", `FWP_RESP_SLVERR, r)
  endtask : sc_reset

  // Blocking run, then a second pass over the same row
  task automatic sc_blocking();
    logic [31:0] d;
    logic [1:0] r;
    fill(8'h40, 0);
    axi_wr(`FWP_OFS_NMI_STATUS_REG, 32'h0, r);
    start(16'h0100, 3'b001);
    while (flashProgMode !== 1'b1) @(posedge clock);
    `CHK("hold in program", 1'b1, cpuHold)
    `CHK("ready in program", 1'b0, flashReadReady)
    wait_idle(d);
    `CHK("blocking carry", 1'b0, d[`FWP_STAT_CARRY])
    `CHK("hold released", 1'b0, d[`FWP_STAT_HOLD])
    `CHK("ready after done", 1'b1, d[`FWP_STAT_RDY])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0120);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h0);
    chk_row(16'h0100, 0, 3);
    fill(8'h40, 1);
    start(16'h0100, 3'b001);
    wait_idle(d);
    `CHK("second pass carry", 1'b0, d[`FWP_STAT_CARRY])
    chk_row(16'h0100, 0, 1);
    `CHK("no pulse in blocking", 0, nmiCount)
  endtask : sc_blocking

  // Background run with a refused restart, then one without the pulse
  task automatic sc_background();
    logic [31:0] d;
    logic [1:0] r;
    fill(8'h80, 2);
    start(16'h0200, 3'b111);
    axi_rd(`FWP_OFS_STAT, d, r);
    `CHK("bg carry", 1'b0, d[`FWP_STAT_CARRY])
    `CHK("bg busy", 1'b1, d[`FWP_STAT_BUSY])
    `CHK("bg no hold", 1'b0, d[`FWP_STAT_HOLD])
    `CHK("bg not readable", 1'b0, d[`FWP_STAT_RDY])
    `CHK("bg prog mode", 1'b1, d[`FWP_STAT_PROG])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0220);
    // Pointer write while busy is ignored; the later readback proves it
    axi_wr(`FWP_OFS_DATA_POINTER, 32'h0000_0300, r);
    `CHK("busy pointer write resp", `FWP_RESP_OKAY, r)
    axi_wr(`FWP_OFS_CTRL, 32'h7, r);
    axi_rd(`FWP_OFS_STAT, d, r);
    `CHK("restart refused", 1'b1, d[`FWP_STAT_CARRY])
    wait_idle(d);
    `CHK("bg readable", 1'b1, d[`FWP_STAT_RDY])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0220);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h1);
    `CHK("one nmi pulse", 1, nmiCount)
    chk_row(16'h0200, 2, 3);
    axi_wr(`FWP_OFS_NMI_STATUS_REG, 32'h0, r);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h0);
    start(16'h0240, 3'b011);
    wait_idle(d);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h1);
    `CHK("no pulse when disabled", 1, nmiCount)
  endtask : sc_background

  // Misaligned pointer, protection and an abort in mid-run
  task automatic sc_reject();
    logic [31:0] d;
    start(16'h0305, 3'b001);
    wait_idle(d);
    `CHK("misaligned carry", 1'b1, d[`FWP_STAT_CARRY])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0305);
    protMode1 <= 1'b1;
    start(16'h0300, 3'b001);
    wait_idle(d);
    protMode1 <= 1'b0;
    `CHK("protected carry", 1'b1, d[`FWP_STAT_CARRY])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0300);
    chk_row(16'h0300, 3, 3);
    start(16'h0300, 3'b001);
    while (flashProgMode !== 1'b1) @(posedge clock);
    nmiEvent <= 1'b1;
    wait_idle(d);
    nmiEvent <= 1'b0;
    `CHK("aborted carry", 1'b1, d[`FWP_STAT_CARRY])
    rd_chk(`FWP_OFS_DATA_POINTER, 32'h0300);
    rd_chk(`FWP_OFS_NMI_STATUS_REG, 32'h0);
  endtask : sc_reject

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    sc_reset();
    sc_blocking();
    sc_background();
    sc_reject();
    tallyAndFinish();
  end
endmodule : fwp_row_program_bench
